//--- hdl/lvr_clkout.sv
// Purpose: power-on / low-voltage reset control, warning interrupt,
//   stop-mode detector gating and divided bus clock on a shared pin
// Assumes: comparator results arrive synchronous to mclk_i; nrst_i is
//   the power-on reset of this block
// Notes: divide ratio of the clock output is 2 to the power of the
//   select value, so select 1 gives half the bus clock
module lvr_clkout (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic above_rearm_i,
  input wire logic above_low_i,
  input wire logic above_high_i,
  input wire logic warn_cond_i,
  input wire logic stop_req_i,
  input wire logic stop_deep_req_i,
  input wire logic wake_i,
  input wire logic port_dir_i,
  input wire logic port_dat_i,
  input wire logic pin_slew_control_i,
  input wire logic pin_drive_control_i,
  output logic sys_reset_o,
  output logic detector_on_o,
  output logic [1:0] stop_mode_o,
  output logic irq_o,
  output logic pin_out_o,
  output logic pin_oe_n_o,
  output logic pin_slew_o,
  output logic pin_drive_o
);

  // bus slave state
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  // control register bits
  logic det_en_r, det_en_nxt;
  logic det_stop_en_r, det_stop_en_nxt;
  logic lvr_en_r, lvr_en_nxt;
  logic thr_sel_r, thr_sel_nxt;
  logic warn_ie_r, warn_ie_nxt;
  logic [2:0] cksel_r, cksel_nxt;
  // status and interrupt
  logic [1:0] src_r, src_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt;
  logic [1:0] irq_mask_r, irq_mask_nxt;
  // reset holds
  logic por_hold_r, por_hold_nxt;
  logic lvr_hold_r, lvr_hold_nxt;
  // stop mode
  lvr_pkg::stop_state_t stop_r, stop_nxt;
  // clock-out divider
  logic [7:0] div_r, div_nxt;
  logic ck_r, ck_nxt;

  logic wr_acc, rd_acc;
  logic above_sel, det_on, lvr_event, warn_event;

  // byte-lane merge of a write onto a held word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // write-one-to-clear with set winning over the clear
  function automatic logic [1:0] w1c(input logic [1:0] old,
                                     input logic [1:0] clr,
                                     input logic [1:0] set);
    return (old & ~clr) | set;
  endfunction

  // control word as software reads it
  function automatic logic [31:0] ctrl_word(input logic de,
    input logic dse, input logic lre, input logic ts, input logic wie,
    input logic wf, input logic [2:0] cs);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[lvr_pkg::CTL_DET_EN] = de;
    w[lvr_pkg::CTL_DET_STOP_EN] = dse;
    w[lvr_pkg::CTL_LVR_EN] = lre;
    w[lvr_pkg::CTL_THR_SEL] = ts;
    w[lvr_pkg::CTL_WARN_IE] = wie;
    w[lvr_pkg::CTL_WARN_FLAG] = wf;
    w[lvr_pkg::CTL_CKSEL_LO +: lvr_pkg::CKSEL_W] = cs;
    return w;
  endfunction

  // the write lands on the edge where the master sees ack
  assign wr_acc = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign rd_acc = wb_cyc_i & wb_stb_i & ~ack_r;

  // detector gating: stop modes switch it off unless stop-enabled
  assign det_on = det_en_r &
    ((stop_r == lvr_pkg::ST_RUN) | det_stop_en_r);
  // selected trip level
  assign above_sel = thr_sel_r ? above_high_i : above_low_i;
  assign lvr_event = det_on & lvr_en_r & ~above_sel;
  assign warn_event = det_on & warn_ie_r & warn_cond_i;

  // bus slave: one wait state, ack dropped the cycle after
  always_comb begin
    ack_nxt = rd_acc;
    rdat_nxt = 32'h0000_0000;
    if (rd_acc) begin
      unique case (wb_adr_i)
        lvr_pkg::ADR_CTRL: rdat_nxt = ctrl_word(det_en_r,
          det_stop_en_r, lvr_en_r, thr_sel_r, warn_ie_r,
          irq_stat_r[lvr_pkg::IRQ_WARN], cksel_r);
        lvr_pkg::ADR_RSTSRC: rdat_nxt = {30'h0, src_r};
        lvr_pkg::ADR_IRQ_STAT: rdat_nxt = {30'h0, irq_stat_r};
        lvr_pkg::ADR_IRQ_MASK: rdat_nxt = {30'h0, irq_mask_r};
        default: rdat_nxt = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  // control and mask registers
  always_comb begin
    logic [31:0] c;
    c = merge(ctrl_word(det_en_r, det_stop_en_r, lvr_en_r, thr_sel_r,
      warn_ie_r, 1'b0, cksel_r), wb_dat_i, wb_sel_i);
    det_en_nxt = det_en_r;
    det_stop_en_nxt = det_stop_en_r;
    lvr_en_nxt = lvr_en_r;
    thr_sel_nxt = thr_sel_r;
    warn_ie_nxt = warn_ie_r;
    cksel_nxt = cksel_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_acc && wb_adr_i == lvr_pkg::ADR_CTRL) begin
      det_en_nxt = c[lvr_pkg::CTL_DET_EN];
      det_stop_en_nxt = c[lvr_pkg::CTL_DET_STOP_EN];
      lvr_en_nxt = c[lvr_pkg::CTL_LVR_EN];
      thr_sel_nxt = c[lvr_pkg::CTL_THR_SEL];
      warn_ie_nxt = c[lvr_pkg::CTL_WARN_IE];
      cksel_nxt = c[lvr_pkg::CTL_CKSEL_LO +: lvr_pkg::CKSEL_W];
    end
    if (wr_acc && wb_adr_i == lvr_pkg::ADR_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask_nxt = wb_dat_i[1:0];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      det_en_r <= lvr_pkg::CTL_DET_EN_RST;
      det_stop_en_r <= lvr_pkg::CTL_DET_STOP_EN_RST;
      lvr_en_r <= lvr_pkg::CTL_LVR_EN_RST;
      thr_sel_r <= lvr_pkg::CTL_THR_SEL_RST;
      warn_ie_r <= lvr_pkg::CTL_WARN_IE_RST;
      cksel_r <= lvr_pkg::CKSEL_RST;
      irq_mask_r <= lvr_pkg::IRQ_MASK_RST;
    end else begin
      det_en_r <= det_en_nxt;
      det_stop_en_r <= det_stop_en_nxt;
      lvr_en_r <= lvr_en_nxt;
      thr_sel_r <= thr_sel_nxt;
      warn_ie_r <= warn_ie_nxt;
      cksel_r <= cksel_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // reset holds and sticky flags; a rearm drop counts as power-on
  always_comb begin
    logic [1:0] clr_src, clr_irq, set_src, set_irq;
    clr_src = 2'h0;
    clr_irq = 2'h0;
    set_src = 2'h0;
    set_irq = 2'h0;
    if (wr_acc && wb_sel_i[0]) begin
      if (wb_adr_i == lvr_pkg::ADR_RSTSRC) clr_src = wb_dat_i[1:0];
      if (wb_adr_i == lvr_pkg::ADR_IRQ_STAT) clr_irq = wb_dat_i[1:0];
    end
    set_src[lvr_pkg::SRC_POR] = ~above_rearm_i;
    set_src[lvr_pkg::SRC_LVD] = ~above_rearm_i | lvr_event;
    set_irq[lvr_pkg::IRQ_WARN] = warn_event;
    set_irq[lvr_pkg::IRQ_LVR] = lvr_event & ~lvr_hold_r;
    src_nxt = w1c(src_r, clr_src, set_src);
    irq_stat_nxt = w1c(irq_stat_r, clr_irq, set_irq);
    // power-on hold released only above the low threshold
    por_hold_nxt = por_hold_r;
    if (!above_rearm_i) por_hold_nxt = 1'b1;
    else if (above_low_i) por_hold_nxt = 1'b0;
    // low-voltage hold released only above the selected threshold
    lvr_hold_nxt = lvr_hold_r;
    if (lvr_event) lvr_hold_nxt = 1'b1;
    else if (above_sel) lvr_hold_nxt = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src_r <= lvr_pkg::SRC_RST; // power-on marks both sources
      irq_stat_r <= 2'h0;
      por_hold_r <= 1'b1; // first power application
      lvr_hold_r <= 1'b0;
    end else begin
      src_r <= src_nxt;
      irq_stat_r <= irq_stat_nxt;
      por_hold_r <= por_hold_nxt;
      lvr_hold_r <= lvr_hold_nxt;
    end
  end

  // stop modes: deep stop is refused while the detector must stay on
  always_comb begin
    stop_nxt = stop_r;
    unique case (stop_r)
      lvr_pkg::ST_RUN: begin
        if (stop_req_i) begin
          if (stop_deep_req_i && !(det_en_r && det_stop_en_r)) begin
            stop_nxt = lvr_pkg::ST_DEEP;
          end else begin
            stop_nxt = lvr_pkg::ST_SHALLOW;
          end
        end
      end
      lvr_pkg::ST_SHALLOW: if (wake_i) stop_nxt = lvr_pkg::ST_RUN;
      lvr_pkg::ST_DEEP: if (wake_i) stop_nxt = lvr_pkg::ST_RUN;
      default: stop_nxt = lvr_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) stop_r <= lvr_pkg::ST_RUN;
    else stop_r <= stop_nxt;
  end

  // clock divider; only the divided tap is registered, so the pin
  // stays glitch-free but a select change may shorten or stretch one half period
  always_comb begin
    div_nxt = div_r + 8'h01;
    ck_nxt = 1'b0;
    if (cksel_r != 3'h0) begin
      ck_nxt = div_nxt[cksel_r - 3'h1];
    end else begin
      div_nxt = lvr_pkg::DIV_RST;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= lvr_pkg::DIV_RST;
      ck_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      ck_r <= ck_nxt;
    end
  end

  // outputs
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign sys_reset_o = por_hold_r | lvr_hold_r;
  assign detector_on_o = det_on;
  assign stop_mode_o = stop_r;
  assign irq_o = |(irq_stat_r & irq_mask_r);
  // clock mode overrides the port direction
  assign pin_out_o = (cksel_r != 3'h0) ? ck_r : port_dat_i;
  assign pin_oe_n_o = (cksel_r != 3'h0) ? 1'b0 : ~port_dir_i;
  assign pin_slew_o = pin_slew_control_i;
  assign pin_drive_o = pin_drive_control_i;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  det_gate_a: assert property (detector_on_o == (det_en_r &&
    (stop_r == lvr_pkg::ST_RUN || det_stop_en_r)))
    else $error("detector gating wrong");
  stop_off_a: assert property (stop_r != lvr_pkg::ST_RUN
    && !det_stop_en_r |-> !detector_on_o)
    else $error("detector on in stop");
  no_deep_a: assert property (stop_r == lvr_pkg::ST_RUN && stop_req_i
    && det_en_r && det_stop_en_r |=> stop_r == lvr_pkg::ST_SHALLOW)
    else $error("deep stop entered with detector kept");
  rearm_rst_a: assert property (!above_rearm_i
    |=> sys_reset_o && src_r == 2'h3)
    else $error("no reset below rearm level");
  por_hold_a: assert property (por_hold_r && above_rearm_i
    && !above_low_i |=> por_hold_r)
    else $error("power-on hold released early");
  lvr_gate_a: assert property (!lvr_en_r && !lvr_hold_r
    && !por_hold_r && above_rearm_i |=> !sys_reset_o)
    else $error("reset without low-voltage enable");
  lvr_hold_a: assert property ($rose(lvr_hold_r)
    |-> sys_reset_o && src_r[lvr_pkg::SRC_LVD])
    else $error("low-voltage reset not flagged");
  warn_set_a: assert property (warn_event
    |=> irq_stat_r[lvr_pkg::IRQ_WARN])
    else $error("warning flag not set");
  clk_off_a: assert property (cksel_r == 3'h0
    |-> pin_oe_n_o == !port_dir_i && pin_out_o == port_dat_i)
    else $error("clock output active with zero select");
  clk_div_a: assert property ($past(cksel_r) == 3'h1
    && $past(cksel_r, 2) == 3'h1 |-> ck_r != $past(ck_r))
    else $error("divide by two not toggling");
  rst_or_a: assert property (lvr_event
    |=> sys_reset_o && lvr_hold_r)
    else $error("enabled low-voltage request gave no reset");
endmodule

//--- shared/lvr_pkg.sv
// Purpose: constants for the low-voltage reset and clock-out block
// Assumes: 32-bit classic Wishbone slave, byte addresses
// Notes: each register takes one aligned word
package lvr_pkg;
  // register byte offsets
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_RSTSRC = 4'h4;
  localparam logic [3:0] ADR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADR_IRQ_MASK = 4'hc;
  // control register fields
  localparam int CTL_DET_EN = 0;
  localparam int CTL_DET_STOP_EN = 1;
  localparam int CTL_LVR_EN = 2;
  localparam int CTL_THR_SEL = 3;
  localparam int CTL_WARN_IE = 4;
  localparam int CTL_WARN_FLAG = 7;
  localparam int CTL_CKSEL_LO = 8;
  localparam int CKSEL_W = 3;
  // reset values of control bits
  localparam logic CTL_DET_EN_RST = 1'b1;
  localparam logic CTL_DET_STOP_EN_RST = 1'b0;
  localparam logic CTL_LVR_EN_RST = 1'b1;
  localparam logic CTL_THR_SEL_RST = 1'b0;
  localparam logic CTL_WARN_IE_RST = 1'b0;
  localparam logic [2:0] CKSEL_RST = 3'h0;
  // reset source fields
  localparam int SRC_POR = 0;
  localparam int SRC_LVD = 1;
  localparam logic [1:0] SRC_RST = 2'h3;
  // interrupt status and mask fields
  localparam int IRQ_WARN = 0;
  localparam int IRQ_LVR = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // clock-out divider counter width
  localparam int DIV_W = 8;
  localparam logic [7:0] DIV_RST = 8'h00;
  // stop mode states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SHALLOW = 2'b01,
    ST_DEEP = 2'b10
  } stop_state_t;
endpackage

//--- tb/test_lvr_clkout.sv
// Purpose: self-checking bench for the reset, warning, stop and clock-out
// Assumes: bus answers one cycle after a request is taken
// Notes: all inputs change by non-blocking assignment at the rising edge
module test_lvr_clkout;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic wb_ack_o, above_rearm_i, above_low_i, above_high_i, warn_cond_i;
  logic stop_req_i, stop_deep_req_i, wake_i, port_dir_i, port_dat_i;
  logic pin_slew_control_i, pin_drive_control_i, sys_reset_o;
  logic detector_on_o, irq_o, pin_out_o, pin_oe_n_o, pin_slew_o;
  logic pin_drive_o;
  logic [1:0] stop_mode_o;
  int n_errors, comparisons, cycles;
  lvr_clkout i_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .above_rearm_i(above_rearm_i),
    .above_low_i(above_low_i), .above_high_i(above_high_i),
    .warn_cond_i(warn_cond_i), .stop_req_i(stop_req_i),
    .stop_deep_req_i(stop_deep_req_i), .wake_i(wake_i),
    .port_dir_i(port_dir_i), .port_dat_i(port_dat_i),
    .pin_slew_control_i(pin_slew_control_i),
    .pin_drive_control_i(pin_drive_control_i), .sys_reset_o(sys_reset_o),
    .detector_on_o(detector_on_o), .stop_mode_o(stop_mode_o),
    .irq_o(irq_o), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o),
    .pin_slew_o(pin_slew_o), .pin_drive_o(pin_drive_o));
  // free-running bus clock, 4 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic complete_run();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard: whole run needs a few thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one classic cycle; ack is looked at only on rising edges
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  // let n edges land, then look at settled outputs
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic t_power_on();
    chk(sys_reset_o, 1'b1);
    @(posedge mclk_i) nrst_i <= 1'b1;
    step(4);
    chk(sys_reset_o, 1'b1);
    @(posedge mclk_i) above_low_i <= 1'b1;
    step(1);
    chk(sys_reset_o, 1'b0);
    rd(lvr_pkg::ADR_RSTSRC, 32'h3);
    rd(lvr_pkg::ADR_CTRL, 32'h5);
    rd(lvr_pkg::ADR_IRQ_MASK, 32'h0);
    rd(4'h2, 32'h0);
    bus(1'b1, lvr_pkg::ADR_RSTSRC, 32'h3);
    @(posedge mclk_i) above_rearm_i <= 1'b0;
    step(1);
    chk(sys_reset_o, 1'b1);
    @(posedge mclk_i) above_rearm_i <= 1'b1;
    step(1);
    chk(sys_reset_o, 1'b0);
    rd(lvr_pkg::ADR_RSTSRC, 32'h3);
  endtask
  task automatic t_low_voltage();
    bus(1'b1, lvr_pkg::ADR_RSTSRC, 32'h3);
    bus(1'b1, lvr_pkg::ADR_IRQ_STAT, 32'h3);
    bus(1'b1, lvr_pkg::ADR_CTRL, 32'hd);
    @(posedge mclk_i) above_high_i <= 1'b0;
    step(1);
    chk(sys_reset_o, 1'b1);
    rd(lvr_pkg::ADR_RSTSRC, 32'h2);
    rd(lvr_pkg::ADR_IRQ_STAT, 32'h2);
    @(posedge mclk_i) above_high_i <= 1'b1;
    step(1);
    chk(sys_reset_o, 1'b0);
    // reset enable off: same dip must not reset
    bus(1'b1, lvr_pkg::ADR_CTRL, 32'h9);
    @(posedge mclk_i) above_high_i <= 1'b0;
    step(2);
    chk(sys_reset_o, 1'b0);
    bus(1'b1, lvr_pkg::ADR_CTRL, 32'hc);
    step(2);
    chk(detector_on_o, 1'b0);
    chk(sys_reset_o, 1'b0);
    @(posedge mclk_i) above_high_i <= 1'b1;
    bus(1'b1, lvr_pkg::ADR_CTRL, 32'h5);
    bus(1'b1, lvr_pkg::ADR_IRQ_STAT, 32'h3);
  endtask
  task automatic t_warning();
    bus(1'b1, lvr_pkg::ADR_IRQ_MASK, 32'h1);
    bus(1'b1, lvr_pkg::ADR_CTRL, 32'h15);
    @(posedge mclk_i) warn_cond_i <= 1'b1;
    step(1);
    chk(irq_o, 1'b1);
    @(posedge mclk_i) warn_cond_i <= 1'b0;
    rd(lvr_pkg::ADR_CTRL, 32'h95);
    bus(1'b1, lvr_pkg::ADR_IRQ_STAT, 32'h1);
    step(1);
    chk(irq_o, 1'b0);
    // masked event still sets the sticky bit, line stays low
    bus(1'b1, lvr_pkg::ADR_IRQ_MASK, 32'h0);
    @(posedge mclk_i) warn_cond_i <= 1'b1;
    @(posedge mclk_i) warn_cond_i <= 1'b0;
    step(1);
    chk(irq_o, 1'b0);
    rd(lvr_pkg::ADR_IRQ_STAT, 32'h1);
    bus(1'b1, lvr_pkg::ADR_IRQ_STAT, 32'h1);
  endtask
  task automatic stop(input logic [31:0] c, input logic d,
                      input logic [1:0] m, input logic on);
    bus(1'b1, lvr_pkg::ADR_CTRL, c);
    @(posedge mclk_i) stop_req_i <= 1'b1;
    stop_deep_req_i <= d;
    @(posedge mclk_i) stop_req_i <= 1'b0;
    @(negedge mclk_i);
    chk(stop_mode_o, m);
    chk(detector_on_o, on);
    @(posedge mclk_i) wake_i <= 1'b1;
    @(posedge mclk_i) wake_i <= 1'b0;
    @(negedge mclk_i);
    chk(stop_mode_o, 2'b00);
  endtask
  task automatic t_stop();
    stop(32'h5, 1'b1, 2'b10, 1'b0);
    stop(32'h7, 1'b1, 2'b01, 1'b1);
    stop(32'h5, 1'b0, 2'b01, 1'b0);
  endtask
  task automatic t_clock_out();
    int first, per, nr;
    logic prev;
    @(posedge mclk_i) port_dat_i <= 1'b1;
    step(1);
    chk(pin_out_o, 1'b1);
    chk(pin_oe_n_o, 1'b0);
    @(posedge mclk_i) port_dir_i <= 1'b0;
    // period measured between two rising edges seen on the pin
    for (int s = 1; s < 8; s++) begin
      bus(1'b1, lvr_pkg::ADR_CTRL, 32'h5 | (s << 8));
      pin_slew_control_i <= s[0];
      pin_drive_control_i <= ~s[0];
      first = -1;
      per = 0;
      nr = 0;
      prev = 1'b1;
      // the first rise may come from the tap switch, so time 2nd to 3rd
      for (int i = 0; i < 400; i++) begin
        @(negedge mclk_i);
        if (pin_out_o === 1'b1 && prev === 1'b0) begin
          nr++;
          if (nr == 3) per = i - first;
          first = i;
        end
        prev = pin_out_o;
      end
      chk(per, 1 << s);
      chk(pin_oe_n_o, 1'b0);
      chk({pin_slew_o, pin_drive_o}, {s[0], ~s[0]});
    end
    bus(1'b1, lvr_pkg::ADR_CTRL, 32'h5);
    @(posedge mclk_i) port_dat_i <= 1'b0;
    step(1);
    chk(pin_out_o, 1'b0);
    chk(pin_oe_n_o, 1'b1);
  endtask
  // every input defined at time zero, reset held through four rising edges
  initial begin
    {nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, above_low_i} = '0;
    {warn_cond_i, stop_req_i, stop_deep_req_i, wake_i} = '0;
    {pin_slew_control_i, pin_drive_control_i, port_dat_i} = '0;
    {above_rearm_i, above_high_i, port_dir_i} = '1;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (3) @(posedge mclk_i);
    t_power_on();
    t_low_voltage();
    t_warning();
    t_stop();
    t_clock_out();
    complete_run();
  end
endmodule
